// >>> inc/dual_wiper_map.vh
// Register map, reset values and timing constants of the dual wiper bank
`ifndef DUAL_WIPER_MAP_VH
`define DUAL_WIPER_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DW_ADDR_WIPER0 8'h00
`define DW_ADDR_WIPER1 8'h01
`define DW_ADDR_CTRL 8'h10

// ----------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------
`define DW_WIPER_RST 8'h40
`define DW_CTRL_RST 8'h40
`define DW_PDN_BIT 6
`define DW_TAP_MASK 8'h7f
`define DW_UNMAPPED_READ 8'h00
`define DW_ID_PREFIX 4'ha

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DW_CLK_MHZ 40
`define DW_MAKE_NS 100
`define DW_SETTLE_NS 1000
`define DW_GLITCH_NS 200

`endif

// >>> verilog/tap_switch_ctrl.v
// Make-before-break tap switch sequencer with shutdown handling
`timescale 1ns/10ps
`default_nettype none
`include "dual_wiper_map.vh"

module tap_switch_ctrl #(
  parameter TAP_W = 7,
  parameter CNT_W = 8,
  parameter [CNT_W-1:0] MAKE_CYC = 8'd4,
  parameter [CNT_W-1:0] SETTLE_CYC = 8'd40
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire [TAP_W-1:0] code_i,
  input wire power_down_n_i,
  output reg [TAP_W-1:0] tap_new_o,
  output reg [TAP_W-1:0] tap_old_o,
  output reg tap_new_en_o,
  output reg tap_old_en_o,
  output reg end_open_o,
  output reg wiper_low_o
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [1:0] ST_RUN = 2'd0;
  localparam [1:0] ST_MAKE = 2'd1;
  localparam [1:0] ST_SHUT = 2'd2;
  localparam [1:0] ST_SETTLE = 2'd3;

  reg [1:0] state;
  reg [CNT_W-1:0] cnt;
  localparam [7:0] TAP_RST = `DW_WIPER_RST;

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_RUN;
      cnt <= {CNT_W{1'b0}};
      tap_new_o <= TAP_RST[TAP_W-1:0];
      tap_old_o <= TAP_RST[TAP_W-1:0];
      tap_new_en_o <= 1'b1;
      tap_old_en_o <= 1'b0;
      end_open_o <= 1'b0;
      wiper_low_o <= 1'b0;
    end else begin
      case (state)
        ST_RUN: begin
          if (!power_down_n_i) begin
            tap_new_en_o <= 1'b0;
            tap_old_en_o <= 1'b0;
            end_open_o <= 1'b1;
            wiper_low_o <= 1'b1;
            state <= ST_SHUT;
          end else if (code_i != tap_new_o) begin
            tap_old_o <= tap_new_o;
            tap_old_en_o <= 1'b1;
            tap_new_o <= code_i;
            cnt <= MAKE_CYC - 1'b1;
            state <= ST_MAKE;
          end
        end
        ST_MAKE: begin
          if (cnt == {CNT_W{1'b0}}) begin
            tap_old_en_o <= 1'b0;
            state <= ST_RUN;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        ST_SHUT: begin
          if (power_down_n_i) begin
            end_open_o <= 1'b0;
            wiper_low_o <= 1'b0;
            tap_new_o <= code_i;
            cnt <= SETTLE_CYC - 1'b1;
            state <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (!power_down_n_i) begin
            end_open_o <= 1'b1;
            wiper_low_o <= 1'b1;
            state <= ST_SHUT;
          end else if (cnt == {CNT_W{1'b0}}) begin
            tap_new_o <= code_i;
            tap_new_en_o <= 1'b1;
            state <= ST_RUN;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

endmodule // tap_switch_ctrl

`default_nettype wire

// >>> verilog/dual_wiper_register_bank.v
// Serial slave, register bank and tap control of a dual 128-tap pot
`timescale 1ns/10ps
`default_nettype none
`include "dual_wiper_map.vh"

module dual_wiper_register_bank #(
  parameter TAP_W = 7,
  parameter CNT_W = 8
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_i,
  input wire addr_sel_bit2_i,
  input wire addr_sel_bit1_i,
  input wire addr_sel_bit0_i,
  input wire supply_low_i,
  output reg sda_o,
  output reg sda_oe_n_o,
  output reg power_down_n_o,
  output wire [TAP_W-1:0] tap_new_0_o,
  output wire [TAP_W-1:0] tap_old_0_o,
  output wire tap_new_en_0_o,
  output wire tap_old_en_0_o,
  output wire end_open_0_o,
  output wire wiper_low_0_o,
  output wire [TAP_W-1:0] tap_new_1_o,
  output wire [TAP_W-1:0] tap_old_1_o,
  output wire tap_new_en_1_o,
  output wire tap_old_en_1_o,
  output wire end_open_1_o,
  output wire wiper_low_1_o
);

  // --------------------------------------------------------------------
  // Timing counts
  // --------------------------------------------------------------------
  localparam integer MAKE_I = (`DW_MAKE_NS * `DW_CLK_MHZ + 999) / 1000;
  localparam integer SETTLE_I = (`DW_SETTLE_NS * `DW_CLK_MHZ + 999) / 1000;
  localparam integer GLITCH_I = (`DW_GLITCH_NS * `DW_CLK_MHZ + 999) / 1000;
  localparam [CNT_W-1:0] MAKE_CYC = MAKE_I[CNT_W-1:0];
  localparam [CNT_W-1:0] SETTLE_CYC = SETTLE_I[CNT_W-1:0];
  localparam [CNT_W-1:0] GLITCH_CYC = GLITCH_I[CNT_W-1:0];

  // --------------------------------------------------------------------
  // Serial states
  // --------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_DEV = 3'd1;
  localparam [2:0] ST_REG = 3'd2;
  localparam [2:0] ST_WR = 3'd3;
  localparam [2:0] ST_RD = 3'd4;

  // --------------------------------------------------------------------
  // Register read decode
  // --------------------------------------------------------------------
  function [7:0] read_reg;
    input [7:0] addr;
    input [7:0] w0;
    input [7:0] w1;
    input pdn;
    begin
      case (addr)
        `DW_ADDR_WIPER0: read_reg = w0;
        `DW_ADDR_WIPER1: read_reg = w1;
        `DW_ADDR_CTRL: read_reg = {1'b0, pdn, 6'h00};
        default: read_reg = `DW_UNMAPPED_READ;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  reg scl_s1, scl_s2, scl_s3;
  reg sda_s1, sda_s2, sda_s3;
  reg sup_s1, sup_s2;
  reg [2:0] addr_s1;
  reg [2:0] addr_s2;

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      sup_s1 <= 1'b0;
      sup_s2 <= 1'b0;
      addr_s1 <= 3'h0;
      addr_s2 <= 3'h0;
    end else begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      sup_s1 <= supply_low_i;
      sup_s2 <= sup_s1;
      addr_s1 <= {addr_sel_bit2_i, addr_sel_bit1_i, addr_sel_bit0_i};
      addr_s2 <= addr_s1;
    end
  end

  wire scl_rise = scl_s2 & ~scl_s3;
  wire scl_fall = ~scl_s2 & scl_s3;
  wire start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  wire stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

  // --------------------------------------------------------------------
  // Serial engine
  // --------------------------------------------------------------------
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shreg;
  reg [7:0] ptr;
  reg [7:0] tx;
  reg [7:0] wiper_position_0;
  reg [7:0] wiper_position_1;

  wire [6:0] own_id = {`DW_ID_PREFIX, addr_s2};
  wire id_match = (shreg[7:1] == own_id);
  wire [2:0] tx_idx = 3'd7 - bit_cnt[2:0];
  wire [7:0] next_ptr = ptr + 8'h01;
  wire [7:0] rd_now = read_reg(ptr, wiper_position_0, wiper_position_1,
                               power_down_n_o);
  wire [7:0] rd_next = read_reg(next_ptr, wiper_position_0,
                                wiper_position_1, power_down_n_o);
  wire ninth_rise = scl_rise & ~start_det & ~stop_det & (bit_cnt == 4'd8);
  wire wr_strobe = ninth_rise & (state == ST_WR);

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      ptr <= 8'h00;
      tx <= 8'h00;
      sda_o <= 1'b0;
      sda_oe_n_o <= 1'b1;
    end else if (start_det) begin
      state <= ST_DEV;
      bit_cnt <= 4'h0;
      sda_oe_n_o <= 1'b1;
    end else if (stop_det) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      sda_oe_n_o <= 1'b1;
    end else if (scl_rise) begin
      case (state)
        ST_DEV, ST_REG, ST_WR: begin
          if (bit_cnt < 4'd8) begin
            shreg <= {shreg[6:0], sda_s2};
            bit_cnt <= bit_cnt + 4'd1;
          end else if (bit_cnt == 4'd8) begin
            bit_cnt <= 4'd9;
          end
        end
        ST_RD: begin
          if (bit_cnt == 4'd8) begin
            if (sda_s2) begin
              state <= ST_IDLE;
            end else begin
              bit_cnt <= 4'd9;
            end
          end else if (bit_cnt < 4'd8) begin
            bit_cnt <= bit_cnt + 4'd1;
          end
        end
        default: begin
          bit_cnt <= bit_cnt;
        end
      endcase
    end else if (scl_fall) begin
      case (state)
        ST_DEV: begin
          if (bit_cnt == 4'd8) begin
            if (id_match) begin
              sda_oe_n_o <= 1'b0;
            end else begin
              state <= ST_IDLE;
            end
          end else if (bit_cnt == 4'd9) begin
            bit_cnt <= 4'h0;
            if (shreg[0]) begin
              state <= ST_RD;
              tx <= rd_now;
              sda_oe_n_o <= rd_now[7];
            end else begin
              state <= ST_REG;
              sda_oe_n_o <= 1'b1;
            end
          end
        end
        ST_REG: begin
          if (bit_cnt == 4'd8) begin
            ptr <= shreg;
            sda_oe_n_o <= 1'b0;
          end else if (bit_cnt == 4'd9) begin
            bit_cnt <= 4'h0;
            state <= ST_WR;
            sda_oe_n_o <= 1'b1;
          end
        end
        ST_WR: begin
          if (bit_cnt == 4'd8) begin
            sda_oe_n_o <= 1'b0;
          end else if (bit_cnt == 4'd9) begin
            bit_cnt <= 4'h0;
            ptr <= next_ptr;
            sda_oe_n_o <= 1'b1;
          end
        end
        ST_RD: begin
          if (bit_cnt == 4'd8) begin
            sda_oe_n_o <= 1'b1;
          end else if (bit_cnt == 4'd9) begin
            bit_cnt <= 4'h0;
            ptr <= next_ptr;
            tx <= rd_next;
            sda_oe_n_o <= rd_next[7];
          end else begin
            sda_oe_n_o <= tx[tx_idx];
          end
        end
        default: begin
          sda_oe_n_o <= 1'b1;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Supply glitch filter
  // --------------------------------------------------------------------
  reg [CNT_W-1:0] glitch_cnt;
  reg glitch_hit;

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      glitch_cnt <= {CNT_W{1'b0}};
      glitch_hit <= 1'b0;
    end else if (!sup_s2) begin
      glitch_cnt <= {CNT_W{1'b0}};
      glitch_hit <= 1'b0;
    end else if (glitch_cnt == GLITCH_CYC - 1'b1) begin
      glitch_hit <= 1'b1;
    end else begin
      glitch_cnt <= glitch_cnt + 1'b1;
    end
  end

  wire glitch_evt = sup_s2 & ~glitch_hit &
                    (glitch_cnt == GLITCH_CYC - 1'b1);

  // --------------------------------------------------------------------
  // Register bank
  // --------------------------------------------------------------------
  localparam [7:0] CTRL_RST = `DW_CTRL_RST;

  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wiper_position_0 <= `DW_WIPER_RST;
      wiper_position_1 <= `DW_WIPER_RST;
      power_down_n_o <= CTRL_RST[`DW_PDN_BIT];
    end else if (glitch_evt && !power_down_n_o) begin
      wiper_position_0 <= `DW_WIPER_RST;
      wiper_position_1 <= `DW_WIPER_RST;
    end else if (wr_strobe) begin
      case (ptr)
        `DW_ADDR_WIPER0: wiper_position_0 <= shreg & `DW_TAP_MASK;
        `DW_ADDR_WIPER1: wiper_position_1 <= shreg & `DW_TAP_MASK;
        `DW_ADDR_CTRL: power_down_n_o <= shreg[`DW_PDN_BIT];
        default: power_down_n_o <= power_down_n_o;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Tap switch control, one per pot
  // --------------------------------------------------------------------
  tap_switch_ctrl #(
    .TAP_W(TAP_W),
    .CNT_W(CNT_W),
    .MAKE_CYC(MAKE_CYC),
    .SETTLE_CYC(SETTLE_CYC)
  ) u_tap0 (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .code_i(wiper_position_0[TAP_W-1:0]),
    .power_down_n_i(power_down_n_o),
    .tap_new_o(tap_new_0_o),
    .tap_old_o(tap_old_0_o),
    .tap_new_en_o(tap_new_en_0_o),
    .tap_old_en_o(tap_old_en_0_o),
    .end_open_o(end_open_0_o),
    .wiper_low_o(wiper_low_0_o)
  );

  tap_switch_ctrl #(
    .TAP_W(TAP_W),
    .CNT_W(CNT_W),
    .MAKE_CYC(MAKE_CYC),
    .SETTLE_CYC(SETTLE_CYC)
  ) u_tap1 (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .code_i(wiper_position_1[TAP_W-1:0]),
    .power_down_n_i(power_down_n_o),
    .tap_new_o(tap_new_1_o),
    .tap_old_o(tap_old_1_o),
    .tap_new_en_o(tap_new_en_1_o),
    .tap_old_en_o(tap_old_en_1_o),
    .end_open_o(end_open_1_o),
    .wiper_low_o(wiper_low_1_o)
  );

endmodule // dual_wiper_register_bank

`default_nettype wire

// >>> testbench/dual_wiper_asserts.sv
// Port checks of the dual wiper register bank
`timescale 1ns/10ps
`default_nettype none

module dual_wiper_checker #(
  parameter TAP_W = 7
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire scl_i,
  input wire sda_o,
  input wire sda_oe_n_o,
  input wire power_down_n_o,
  input wire [TAP_W-1:0] tap_new_0_o,
  input wire [TAP_W-1:0] tap_old_0_o,
  input wire [TAP_W-1:0] tap_new_1_o,
  input wire [TAP_W-1:0] tap_old_1_o,
  input wire tap_new_en_0_o,
  input wire tap_old_en_0_o,
  input wire end_open_0_o,
  input wire wiper_low_0_o,
  input wire tap_new_en_1_o,
  input wire tap_old_en_1_o,
  input wire end_open_1_o,
  input wire wiper_low_1_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // ------
  // Checks
  // ------
  a_sda_open_drain: assert property (!sda_oe_n_o |-> !sda_o)
    else $error("Data line driven high");
  a_pull_after_fall: assert property ($fell(sda_oe_n_o) |->
    !$past(scl_i, 2))
    else $error("Data line pulled outside clock low");
  a_mbb_pot0: assert property ($rose(tap_old_en_0_o) |->
    (tap_old_en_0_o && tap_new_en_0_o) [*4] ##1 !tap_old_en_0_o)
    else $error("Pot 0 switch order wrong");
  a_mbb_pot1: assert property ($rose(tap_old_en_1_o) |->
    (tap_old_en_1_o && tap_new_en_1_o) [*4] ##1 !tap_old_en_1_o)
    else $error("Pot 1 switch order wrong");
  a_old_tap_prev: assert property ($rose(tap_old_en_0_o) |->
    tap_old_0_o == $past(tap_new_0_o))
    else $error("Old tap not previous tap");
  a_old_tap_pot1: assert property ($rose(tap_old_en_1_o) |->
    tap_old_1_o == $past(tap_new_1_o))
    else $error("Pot 1 old tap not previous tap");
  a_power_down_n_enter: assert property ($fell(power_down_n_o) |=>
    end_open_0_o && wiper_low_0_o && !tap_new_en_0_o &&
    end_open_1_o && wiper_low_1_o)
    else $error("Shutdown not entered");
  a_power_down_n_steady: assert property (
    !power_down_n_o && !$past(power_down_n_o) |->
    end_open_0_o && end_open_1_o && !tap_new_en_1_o)
    else $error("Shutdown not held");
  a_power_down_n_exit: assert property ($rose(power_down_n_o) |=>
    (!end_open_0_o && !tap_new_en_0_o) [*8] ##[20:40] tap_new_en_0_o)
    else $error("Shutdown exit timing wrong");
  a_reset_state: assert property ($fell(rst_i) |->
    power_down_n_o && tap_new_0_o == 7'h40 &&
    tap_new_1_o == 7'h40 && !end_open_0_o)
    else $error("Reset state wrong");
  a_ctrl_on_scl: assert property ($changed(power_down_n_o) |->
    $past(scl_i, 2))
    else $error("Control changed off clock high");

  cover property ($rose(tap_old_en_0_o));
  cover property ($fell(power_down_n_o));
  cover property ($fell(sda_oe_n_o));
endmodule // dual_wiper_checker

bind dual_wiper_register_bank dual_wiper_checker #(.TAP_W(TAP_W)) chk (.*);

`default_nettype wire

// >>> testbench/i2c_master_model.sv
// Serial bus master model, 200 ns bit period
`timescale 1ns/10ps
`default_nettype none

module i2c_master_model (
  output logic scl_o,
  output logic sda_o,
  input wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // ----------
  // Bus cycles
  // ----------
  task automatic start();
    sda_o = 1'b1;
    #50 scl_o = 1'b1;
    #100 sda_o = 1'b0;
    #100 scl_o = 1'b0;
    #50;
  endtask

  task automatic stop();
    sda_o = 1'b0;
    #50 scl_o = 1'b1;
    #100 sda_o = 1'b1;
    #100;
  endtask

  // Data set in clock low, sampled in the middle of clock high
  task automatic bit_io(input logic b, output logic r);
    sda_o = b;
    #50 scl_o = 1'b1;
    #50 r = sda_i;
    #50 scl_o = 1'b0;
    #50;
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(nack, r);
  endtask
endmodule // i2c_master_model

`default_nettype wire

// >>> testbench/test_dual_wiper_register_bank.sv
// Bench of the dual wiper register bank
`timescale 1ns/10ps
`default_nettype none
`include "dual_wiper_map.vh"

module test_dual_wiper_register_bank;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic supply_low_i = 1'b0;
  logic [2:0] sel = 3'h5;
  logic m_scl;
  logic m_sda;
  wire sda_o;
  wire sda_oe_n_o;
  wire power_down_n_o;
  wire [6:0] tap_new_0_o;
  wire [6:0] tap_new_1_o;
  wire tap_new_en_0_o;
  wire end_open_0_o;
  wire wiper_low_0_o;
  wire sda_w = m_sda & (sda_oe_n_o | sda_o);
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [7:0] v;
  logic [7:0] v2;
  logic ak;

  i2c_master_model mst (.scl_o(m_scl), .sda_o(m_sda), .sda_i(sda_w));

  dual_wiper_register_bank dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .scl_i(m_scl), .sda_i(sda_w),
    .addr_sel_bit2_i(sel[2]), .addr_sel_bit1_i(sel[1]),
    .addr_sel_bit0_i(sel[0]), .supply_low_i(supply_low_i),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .power_down_n_o(power_down_n_o),
    .tap_new_0_o(tap_new_0_o), .tap_old_0_o(), .tap_new_en_0_o(tap_new_en_0_o),
    .tap_old_en_0_o(), .end_open_0_o(end_open_0_o),
    .wiper_low_0_o(wiper_low_0_o), .tap_new_1_o(tap_new_1_o), .tap_old_1_o(),
    .tap_new_en_1_o(), .tap_old_en_1_o(), .end_open_1_o(), .wiper_low_1_o()
  );

  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors++;
      stop_test();
    end
  end

  // -----
  // Tasks
  // -----
  task automatic stop_test();
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic clk(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, d, d2, input bit two);
    mst.start();
    mst.wr_byte({`DW_ID_PREFIX, sel, 1'b0}, ak);
    check("id ack", ak, 1);
    mst.wr_byte(a, ak);
    check("addr ack", ak, 1);
    mst.wr_byte(d, ak);
    check("data ack", ak, 1);
    if (two) mst.wr_byte(d2, ak);
    mst.stop();
  endtask

  task automatic rd(input logic [7:0] a, input bit two);
    mst.start();
    mst.wr_byte({`DW_ID_PREFIX, sel, 1'b0}, ak);
    mst.wr_byte(a, ak);
    mst.start();
    mst.wr_byte({`DW_ID_PREFIX, sel, 1'b1}, ak);
    check("read id ack", ak, 1);
    mst.rd_byte(!two, v);
    if (two) mst.rd_byte(1'b1, v2);
    mst.stop();
  endtask

  task automatic glitch();
    clk(1);
    supply_low_i = 1'b1;
    clk(20);
    supply_low_i = 1'b0;
    clk(5);
  endtask

  // --------
  // Sequence
  // --------
  initial begin
    clk(5);
    rst_i = 1'b0;
    clk(8);
    rd(`DW_ADDR_WIPER0, 1);
    check("wiper0 rst", v, `DW_WIPER_RST);
    check("wiper1 rst", v2, `DW_WIPER_RST);
    rd(`DW_ADDR_CTRL, 0);
    check("ctrl rst", v, `DW_CTRL_RST);
    check("pdn rst", power_down_n_o, 1);
    wr(`DW_ADDR_WIPER0, 8'h7f, 8'h00, 1);
    clk(10);
    check("tap0 high", tap_new_0_o, 8'h7f);
    check("tap1 low", tap_new_1_o, 8'h00);
    rd(`DW_ADDR_WIPER0, 1);
    check("wiper0", v, 8'h7f);
    check("wiper1", v2, 8'h00);
    wr(`DW_ADDR_WIPER1, 8'hff, 0, 0);
    rd(`DW_ADDR_WIPER1, 0);
    check("wiper1 mask", v, `DW_TAP_MASK);
    for (int k = 0; k < 3; k++) begin
      mst.start();
      mst.wr_byte(k == 0 ? {4'hb, sel, 1'b0} :
        {`DW_ID_PREFIX, sel ^ 3'(k * 3), 1'b0}, ak);
      check("bad id ack", ak, 0);
      mst.stop();
    end
    clk(1);
    sel = 3'h2;
    wr(8'h05, 8'h33, 0, 0);
    rd(8'h05, 0);
    check("unmapped", v, `DW_UNMAPPED_READ);
    rd(`DW_ADDR_WIPER0, 0);
    check("wiper0 kept", v, 8'h7f);
    wr(`DW_ADDR_CTRL, 8'hff, 0, 0);
    rd(`DW_ADDR_CTRL, 0);
    check("ctrl reserved", v, 8'h40);
    wr(`DW_ADDR_WIPER1, 8'h22, 0, 0);
    wr(`DW_ADDR_CTRL, 8'h00, 0, 0);
    clk(3);
    check("pdn", power_down_n_o, 0);
    check("end open", end_open_0_o, 1);
    check("wiper low", wiper_low_0_o, 1);
    rd(`DW_ADDR_WIPER0, 1);
    check("wiper0 held", v, 8'h7f);
    check("wiper1 held", v2, 8'h22);
    glitch();
    rd(`DW_ADDR_WIPER0, 1);
    check("wiper0 glitch", v, `DW_WIPER_RST);
    check("wiper1 glitch", v2, `DW_WIPER_RST);
    wr(`DW_ADDR_CTRL, 8'h40, 0, 0);
    clk(60);
    check("tap0 back", tap_new_0_o, 8'h40);
    check("tap0 on", tap_new_en_0_o, 1);
    check("end closed", end_open_0_o, 0);
    wr(`DW_ADDR_WIPER0, 8'h15, 0, 0);
    glitch();
    check("tap0 kept", tap_new_0_o, 8'h15);
    rst_i = 1'b1;
    clk(2);
    rst_i = 1'b0;
    clk(5);
    check("tap0 rst again", tap_new_0_o, `DW_WIPER_RST);
    rd(`DW_ADDR_WIPER0, 0);
    check("wiper0 rst again", v, `DW_WIPER_RST);
    stop_test();
  end
endmodule // test_dual_wiper_register_bank

`default_nettype wire
